// ---- hw/flash_ctrl.sv ----
// The register addresses and register access over APB were left to the implementer.
`default_nettype none
// Overview of operation
// RULE1: A reset during a running algorithm brings the flash back to reading within 20 us.
// RULE2: A reset with no algorithm running brings the flash back to reading within 500 ns.
// RULE3: After releasing reset the controller waits at least 200 ns before any read.
// RULE4: Holding reset low for at least 20 us puts the flash in standby.
// RULE5: An accelerated program typically ends about 5 us after its last write cycle.
// RULE6: The flash shows busy on ready_busy_n within 90 ns after accepting program or erase.
// RULE7: The flash adds no latency for a read of one bank right after a write to the other.
// RULE8: The erase-suspend toggle bit toggles only when read inside an erase-suspended sector.
// RULE9: The controller may pulse either output enable or chip enable for status reads.
// RULE10: The busy toggle bit is readable at any address while an algorithm runs.
// RULE11: Protect is selected with address bit six low, bit one high and bit zero low.
// RULE12: Unprotect is selected with address bit six high, bit one high and bit zero low.
// RULE13: For temporary unprotect, reset is held raised at least 4 us before the first write.
// RULE14: Leaving temporary unprotect, reset stays raised at least 4 us after ready returns.
// RULE15: While an algorithm runs the poll bit reads inverted data and true data at the end.
// RULE16: The flash holds ready_busy_n busy for the whole algorithm and releases it after.
// RULE17: Completion is found from ready_busy_n or from toggle bits that stop toggling.
module flash_ctrl
  import flash_ctrl_pkg::*;
#(
  parameter int unsigned TU_SETUP_CYCLES = TU_SETUP_CYC,
  parameter int unsigned TU_HOLD_CYCLES = TU_HOLD_CYC
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  output logic flash_reset_n_o,
  output logic [ADDR_W-1:0] flash_addr_o,
  output logic [DATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [DATA_W-1:0] flash_dq_i,
  input wire logic ready_busy_n_i
);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  state_t state_q, state_d;
  flash_pins_t pins_q, pins_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [DATA_W-1:0] prev_q, prev_d;
  logic have_prev_q, have_prev_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic toggle_stop_q, toggle_stop_d;
  logic temp_q, temp_d;
  logic use_ce_q;
  logic [2:0] cmd_q, cmd_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire apb_setup = psel_i && !penable_i;
  wire apb_wr = psel_i && penable_i && pready_q && pwrite_i;
  wire apb_rd = apb_setup && !pwrite_i;
  wire hit_ctrl = (paddr_i == REG_CTRL);
  wire hit_addr = (paddr_i == REG_ADDR);
  wire hit_wdata = (paddr_i == REG_WDATA);
  wire hit_rdata = (paddr_i == REG_RDATA);
  wire hit_status = (paddr_i == REG_STATUS);
  wire hit_any = hit_ctrl || hit_addr || hit_wdata || hit_rdata || hit_status;
  wire [2:0] new_cmd = pwdata_i[CTRL_CMD_LSB +: 3];
  wire start = apb_wr && hit_ctrl && !busy_q && (new_cmd != CMD_NONE);
  wire [31:0] status_word = {27'h0, temp_q, toggle_stop_q, done_q, ready_busy_n_i, busy_q};
  wire [31:0] ctrl_word = {26'h0, use_ce_q, temp_q, 1'b0, cmd_q};
  wire [31:0] rd_mux =
    hit_ctrl ? ctrl_word :
    hit_addr ? {{(32-ADDR_W){1'b0}}, addr_q} :
    hit_wdata ? {{(32-DATA_W){1'b0}}, wdata_q} :
    hit_rdata ? {{(32-DATA_W){1'b0}}, rdata_q} :
    hit_status ? status_word : 32'h0;

  // Sector protect selection on the low address bits
  function automatic logic [ADDR_W-1:0] prot_addr(input logic [ADDR_W-1:0] a,
                                                   input logic unprot);
    logic [ADDR_W-1:0] r;
    r = a;
    r[ADDR_BIT_SIX] = unprot; // RULE11 RULE12
    r[ADDR_BIT_ONE] = 1'b1; // RULE11 RULE12
    r[ADDR_BIT_ZERO] = 1'b0; // RULE11 RULE12
    return r;
  endfunction : prot_addr

  wire [DATA_W-1:0] toggled = flash_dq_i ^ prev_q;
  wire toggles_quiet = !toggled[BUSY_TOGGLE_BIT] && !toggled[ERASE_SUSPEND_TOGGLE_BIT];
  wire cnt_zero = (cnt_q == '0);

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    pins_d = pins_q;
    cnt_d = cnt_zero ? cnt_q : cnt_q - 1'b1;
    rdata_d = rdata_q;
    prev_d = prev_q;
    have_prev_d = have_prev_q;
    busy_d = busy_q;
    done_d = done_q;
    toggle_stop_d = toggle_stop_q;
    temp_d = temp_q;
    cmd_d = cmd_q;
    case (state_q)
      S_IDLE: begin
        if (start) begin
          busy_d = 1'b1;
          done_d = 1'b0;
          cmd_d = new_cmd;
          toggle_stop_d = 1'b0;
          have_prev_d = 1'b0;
          pins_d.addr = addr_q;
          if (new_cmd == CMD_RESET) begin
            pins_d.reset_n = 1'b0;
            cnt_d = CNT_W'(ABORT_READY_CYC); // RULE1 RULE2 RULE4
            state_d = S_RST_LO;
          end else if (pwdata_i[CTRL_TEMP_UNPROT] && !temp_q) begin
            temp_d = 1'b1;
            cnt_d = CNT_W'(TU_SETUP_CYCLES); // RULE13
            state_d = S_TU_SETUP;
          end else if (new_cmd == CMD_READ || new_cmd == CMD_POLL) begin
            pins_d.ce_n = 1'b0;
            pins_d.oe_n = 1'b0; // RULE9
            cnt_d = CNT_W'(READ_CYC);
            state_d = S_RD;
          end else begin
            if (new_cmd == CMD_PROTECT || new_cmd == CMD_UNPROTECT) begin
              pins_d.addr = prot_addr(addr_q, new_cmd == CMD_UNPROTECT);
            end
            pins_d.ce_n = 1'b0;
            pins_d.we_n = 1'b0;
            pins_d.dq_o = wdata_q;
            pins_d.dq_oe = 1'b1;
            cnt_d = CNT_W'(WE_PULSE_CYC);
            state_d = S_WR_LO;
          end
        end else if (!pwdata_i[CTRL_TEMP_UNPROT] && apb_wr && hit_ctrl && temp_q && !busy_q) begin
          busy_d = 1'b1;
          cnt_d = CNT_W'(TU_HOLD_CYCLES); // RULE14
          state_d = S_TU_HOLD;
        end
      end
      S_TU_SETUP: begin
        if (cnt_zero) begin
          have_prev_d = 1'b0;
          if (cmd_q == CMD_READ || cmd_q == CMD_POLL) begin
            pins_d.ce_n = 1'b0;
            pins_d.oe_n = 1'b0;
            cnt_d = CNT_W'(READ_CYC);
            state_d = S_RD;
          end else begin
            if (cmd_q == CMD_PROTECT || cmd_q == CMD_UNPROTECT) begin
              pins_d.addr = prot_addr(addr_q, cmd_q == CMD_UNPROTECT);
            end
            pins_d.ce_n = 1'b0;
            pins_d.we_n = 1'b0;
            pins_d.dq_o = wdata_q;
            pins_d.dq_oe = 1'b1;
            cnt_d = CNT_W'(WE_PULSE_CYC); // RULE13
            state_d = S_WR_LO;
          end
        end
      end
      S_TU_HOLD: begin
        if (!ready_busy_n_i) begin
          cnt_d = CNT_W'(TU_HOLD_CYCLES); // RULE14
        end else if (cnt_zero) begin
          temp_d = 1'b0;
          busy_d = 1'b0;
          done_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_WR_LO: begin
        if (cnt_zero) begin
          pins_d.we_n = 1'b1;
          pins_d.ce_n = 1'b1;
          cnt_d = CNT_W'(WE_HIGH_CYC);
          state_d = S_WR_HI;
        end
      end
      S_WR_HI: begin
        if (cnt_zero) begin
          pins_d.dq_oe = 1'b0;
          busy_d = 1'b0;
          done_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_RD: begin
        if (cnt_zero) begin
          rdata_d = flash_dq_i;
          pins_d.oe_n = 1'b1;
          if (use_ce_q) begin
            pins_d.ce_n = 1'b1; // RULE9
          end
          if (cmd_q == CMD_POLL) begin
            // Busy toggle bit is read at any address; compare two reads
            prev_d = flash_dq_i; // RULE10
            have_prev_d = 1'b1;
            if (have_prev_q && toggles_quiet) begin
              toggle_stop_d = 1'b1; // RULE17
              busy_d = 1'b0;
              done_d = 1'b1;
              pins_d.ce_n = 1'b1;
              state_d = S_IDLE;
            end else begin
              cnt_d = CNT_W'(OE_HIGH_CYC);
              state_d = S_RD_GAP;
            end
          end else begin
            pins_d.ce_n = 1'b1;
            busy_d = 1'b0;
            done_d = 1'b1;
            state_d = S_IDLE;
          end
        end
      end
      S_RD_GAP: begin
        if (cnt_zero) begin
          pins_d.ce_n = 1'b0;
          pins_d.oe_n = 1'b0;
          cnt_d = CNT_W'(READ_CYC);
          state_d = S_RD;
        end
      end
      S_RST_LO: begin
        if (cnt_zero) begin
          pins_d.reset_n = 1'b1;
          cnt_d = CNT_W'(RESET_HIGH_CYC); // RULE3
          state_d = S_RST_HI;
        end
      end
      S_RST_HI: begin
        if (cnt_zero) begin
          state_d = S_BUSY_WAIT;
        end
      end
      S_BUSY_WAIT: begin
        if (ready_busy_n_i) begin
          busy_d = 1'b0; // RULE16 RULE17
          done_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // Flops
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= S_IDLE;
      pins_q <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1,
                  addr: '0, dq_o: '0, dq_oe: 1'b0};
      cnt_q <= '0;
      rdata_q <= '0;
      prev_q <= '0;
      have_prev_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      toggle_stop_q <= 1'b0;
      temp_q <= 1'b0;
      cmd_q <= CMD_NONE;
    end else begin
      state_q <= state_d;
      pins_q <= pins_d;
      cnt_q <= cnt_d;
      rdata_q <= rdata_d;
      prev_q <= prev_d;
      have_prev_q <= have_prev_d;
      busy_q <= busy_d;
      done_q <= done_d;
      toggle_stop_q <= toggle_stop_d;
      temp_q <= temp_d;
      cmd_q <= cmd_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr_q <= '0;
      wdata_q <= '0;
      use_ce_q <= 1'b0;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup && !hit_any;
      if (apb_rd) begin
        prdata_q <= rd_mux;
      end
      if (apb_wr && hit_addr) begin
        addr_q <= pwdata_i[ADDR_W-1:0];
      end
      if (apb_wr && hit_wdata) begin
        wdata_q <= pwdata_i[DATA_W-1:0];
      end
      if (apb_wr && hit_ctrl && !busy_q) begin
        use_ce_q <= pwdata_i[CTRL_USE_CE_TOGGLE];
      end
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign flash_ce_n_o = pins_q.ce_n;
  assign flash_oe_n_o = pins_q.oe_n;
  assign flash_we_n_o = pins_q.we_n;
  assign flash_reset_n_o = pins_q.reset_n;
  assign flash_addr_o = pins_q.addr;
  assign flash_dq_o = pins_q.dq_o;
  assign flash_dq_oe_o = pins_q.dq_oe;
endmodule : flash_ctrl
`default_nettype wire

// ---- hw/flash_ctrl_pkg.sv ----
`default_nettype none
package flash_ctrl_pkg;
  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned RESET_PULSE_NS = 500;
  localparam int unsigned RESET_HIGH_BEFORE_READ_NS = 200;
  localparam int unsigned ABORT_READY_US = 20;
  localparam int unsigned TEMP_UNPROTECT_RESET_SETUP_US = 4;
  localparam int unsigned TEMP_UNPROTECT_RESET_HOLD_US = 4;
  localparam int unsigned BUSY_DELAY_NS = 90;
  localparam int unsigned WE_PULSE_NS = 60;
  localparam int unsigned WE_HIGH_NS = 60;
  localparam int unsigned READ_ACCESS_NS = 100;
  localparam int unsigned OE_HIGH_POLL_NS = 20;
  localparam int unsigned RESET_PULSE_CYC =
    (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_HIGH_CYC =
    (RESET_HIGH_BEFORE_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ABORT_READY_CYC = ABORT_READY_US * CLK_MHZ;
  localparam int unsigned TU_SETUP_CYC = TEMP_UNPROTECT_RESET_SETUP_US * CLK_MHZ;
  localparam int unsigned TU_HOLD_CYC = TEMP_UNPROTECT_RESET_HOLD_US * CLK_MHZ;
  localparam int unsigned BUSY_DELAY_CYC =
    (BUSY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WE_PULSE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WE_HIGH_CYC = (WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OE_HIGH_CYC = (OE_HIGH_POLL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 16;
  // ------------------------------------------------------------
  // Flash bus
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 21;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_BIT_SIX = 6;
  localparam int unsigned ADDR_BIT_ONE = 1;
  localparam int unsigned ADDR_BIT_ZERO = 0;
  localparam int unsigned BUSY_TOGGLE_BIT = 6;
  localparam int unsigned ERASE_SUSPEND_TOGGLE_BIT = 2;
  localparam int unsigned INVERTED_POLL_BIT = 7;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int unsigned CTRL_CMD_LSB = 0;
  localparam int unsigned CTRL_TEMP_UNPROT = 4;
  localparam int unsigned CTRL_USE_CE_TOGGLE = 5;
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_READ = 3'h1;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_RESET = 3'h3;
  localparam logic [2:0] CMD_POLL = 3'h4;
  localparam logic [2:0] CMD_PROTECT = 3'h5;
  localparam logic [2:0] CMD_UNPROTECT = 3'h6;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_READY_BUSY_N = 1;
  localparam int unsigned ST_DONE = 2;
  localparam int unsigned ST_TOGGLE_STOP = 3;
  localparam int unsigned ST_TEMP_ACTIVE = 4;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe;
  } flash_pins_t;

  typedef enum logic [3:0] {
    S_IDLE, S_WR_LO, S_WR_HI, S_RD, S_RD_GAP, S_RST_LO, S_RST_HI,
    S_TU_SETUP, S_TU_HOLD, S_BUSY_WAIT
  } state_t;
endpackage : flash_ctrl_pkg
`default_nettype wire

// ---- testbench/flash_model.sv ----
`default_nettype none
module flash_model #(
  parameter int unsigned PROG_CYC = 250
) (
  input wire logic core_clk_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic reset_n_i,
  input wire logic [20:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic ready_busy_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Array, algorithm timer, status bits
  // ----------------------------------------
  logic [15:0] mem [16];
  logic [15:0] pd_q = 16'h0;
  logic [15:0] last_q = 16'h0;
  logic [15:0] cnt_q = 16'h0;
  logic busy_q = 1'b0;
  logic tog_q = 1'b0;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  wire rd = !ce_n_i && !oe_n_i && we_n_i;
  wire wr = !ce_n_i && !we_n_i;
  assign dq_o = !rd ? ~last_q : busy_q ?
    {pd_q[15:8], ~pd_q[7], tog_q, pd_q[5:0]} : mem[addr_i[3:0]];
  always_ff @(posedge core_clk_i) begin
    rd_q <= rd;
    wr_q <= wr;
    if (!reset_n_i) begin
      busy_q <= 1'b0;
      ready_busy_n_o <= 1'b1;
    end else if (wr_q && !wr && !busy_q) begin
      busy_q <= 1'b1;
      ready_busy_n_o <= 1'b0;
      cnt_q <= 16'(PROG_CYC);
      pd_q <= dq_i;
      mem[addr_i[3:0]] <= dq_i;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 16'h1;
      if (cnt_q == 16'h1) begin
        busy_q <= 1'b0;
        ready_busy_n_o <= 1'b1;
      end
    end
    if (rd && !rd_q) tog_q <= ~tog_q;
    if (rd) last_q <= dq_o;
  end
endmodule : flash_model
`default_nettype wire

// ---- testbench/flash_ctrl_assertions.sv ----
`default_nettype none
module flash_ctrl_assertions
  import flash_ctrl_pkg::*;
#(
  parameter int unsigned TU_SETUP_CYCLES = TU_SETUP_CYC,
  parameter int unsigned TU_HOLD_CYCLES = TU_HOLD_CYC
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic flash_ce_n_o,
  input wire logic flash_oe_n_o,
  input wire logic flash_we_n_o,
  input wire logic flash_reset_n_o,
  input wire logic [ADDR_W-1:0] flash_addr_o,
  input wire logic [DATA_W-1:0] flash_dq_o,
  input wire logic flash_dq_oe_o,
  input wire logic [DATA_W-1:0] flash_dq_i,
  input wire logic ready_busy_n_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Helpers and properties
  // ----------------------------------------
  logic [2:0] cmd_q;
  logic [10:0] low_q;
  wire setup = psel_i && !penable_i;
  wire mapped = paddr_i inside {REG_CTRL, REG_ADDR, REG_WDATA, REG_RDATA, REG_STATUS};
  wire [2:0] pin3 = {flash_addr_o[ADDR_BIT_SIX], flash_addr_o[ADDR_BIT_ONE],
    flash_addr_o[ADDR_BIT_ZERO]};
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_q <= CMD_NONE;
      low_q <= 11'h0;
    end else begin
      if (setup && pwrite_i && paddr_i == REG_CTRL) cmd_q <= pwdata_i[2:0];
      low_q <= flash_reset_n_o ? 11'h0 : low_q + 11'h1;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_wr_pulse;
    (!flash_we_n_o && !flash_ce_n_o) [*4] ##1 flash_we_n_o;
  endsequence
  sequence s_oe_quiet;
    flash_oe_n_o [*8] ##1 flash_oe_n_o [*2];
  endsequence
  property p_ready;
    setup |=> pready_o ##1 !pready_o;
  endproperty
  property p_unmapped;
    setup && !mapped |=> pready_o && pslverr_o && (pwrite_i || prdata_o == 32'h0);
  endproperty
  property p_rst_gap;
    $rose(flash_reset_n_o) |-> s_oe_quiet;
  endproperty
  property p_rst_len;
    $rose(flash_reset_n_o) |-> low_q >= 11'd1000;
  endproperty
  property p_we;
    $fell(flash_we_n_o) |-> s_wr_pulse;
  endproperty
  property p_busy_hold;
    !ready_busy_n_i && flash_we_n_o |=> flash_we_n_o;
  endproperty
  property p_prot;
    $fell(flash_we_n_o) && cmd_q == CMD_PROTECT |-> pin3 == 3'b010;
  endproperty
  property p_unprot;
    $fell(flash_we_n_o) && cmd_q == CMD_UNPROTECT |-> pin3 == 3'b110;
  endproperty
  property p_dq_oe;
    flash_dq_oe_o |-> flash_oe_n_o;
  endproperty
  a_ready: assert property (p_ready) else $error("pready not one cycle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  a_rst_gap: assert property (p_rst_gap) else $error("read too soon");
  a_rst_len: assert property (p_rst_len) else $error("reset too short");
  a_we: assert property (p_we) else $error("bad write pulse");
  a_busy_hold: assert property (p_busy_hold) else $error("write while busy");
  a_prot: assert property (p_prot) else $error("protect address");
  a_unprot: assert property (p_unprot) else $error("unprotect address");
  a_dq_oe: assert property (p_dq_oe) else $error("bus contention");
endmodule : flash_ctrl_assertions
bind flash_ctrl flash_ctrl_assertions #(.TU_SETUP_CYCLES(TU_SETUP_CYCLES),
  .TU_HOLD_CYCLES(TU_HOLD_CYCLES)) chk_u (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .flash_ce_n_o(flash_ce_n_o),
  .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o),
  .flash_reset_n_o(flash_reset_n_o), .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o),
  .flash_dq_oe_o(flash_dq_oe_o), .flash_dq_i(flash_dq_i), .ready_busy_n_i(ready_busy_n_i));
`default_nettype wire

// ---- testbench/flash_reset_program_erase_timing_bench.sv ----
`default_nettype none
module flash_reset_program_erase_timing_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_ctrl_pkg::*;
  logic core_clk_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_reset_n_o, flash_dq_oe_o;
  logic ready_busy_n_i, err;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [ADDR_W-1:0] flash_addr_o, we_addr;
  logic [DATA_W-1:0] flash_dq_o, flash_dq_i;
  int errors = 0;
  int checks = 0;
  flash_ctrl #(.TU_SETUP_CYCLES(4), .TU_HOLD_CYCLES(4)) dut_u (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .flash_ce_n_o(flash_ce_n_o),
    .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o),
    .flash_reset_n_o(flash_reset_n_o), .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o), .flash_dq_i(flash_dq_i), .ready_busy_n_i(ready_busy_n_i));
  flash_model dev_u (.core_clk_i(core_clk_i), .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o),
    .we_n_i(flash_we_n_o), .reset_n_i(flash_reset_n_o & resetn_i), .addr_i(flash_addr_o),
    .dq_i(flash_dq_o), .dq_o(flash_dq_i), .ready_busy_n_o(ready_busy_n_i));
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) if (flash_we_n_o === 1'b0) we_addr <= flash_addr_o;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wait_idle(input logic rb);
    int n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while ((rd[0] !== 1'b0 || (rb && rd[1] !== 1'b1)) && n < 600);
    if (n == 600) cmp("idle_wait", 32'h0, 32'h1);
  endtask : wait_idle
  task automatic stop_test;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    apb(1'b0, REG_STATUS, 32'h0);
    cmp("status_rst", 32'h2, rd);
    apb(1'b1, 8'h14, 32'h1);
    cmp("wr_err", 32'h1, {31'h0, err});
    apb(1'b0, 8'h14, 32'h0);
    cmp("rd_err", 32'h1, {31'h0, err});
    cmp("rd_zero", 32'h0, rd);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_prog(input logic [31:0] a, input logic [31:0] d, input logic [31:0] x);
    apb(1'b1, REG_ADDR, a);
    apb(1'b1, REG_WDATA, d);
    apb(1'b1, REG_CTRL, {29'h0, CMD_WRITE});
    wait_idle(1'b0);
    cmp("dev_busy", 32'h0, rd & 32'h2);
    apb(1'b1, REG_CTRL, {29'h0, CMD_READ});
    wait_idle(1'b0);
    apb(1'b0, REG_RDATA, 32'h0);
    cmp("poll_inv", {31'h0, ~d[7]}, {31'h0, rd[7]});
    apb(1'b1, REG_CTRL, x | {29'h0, CMD_POLL});
    wait_idle(1'b0);
    cmp("poll_status", 32'he, rd);
    apb(1'b0, REG_RDATA, 32'h0);
    cmp("poll_data", d, rd);
    apb(1'b1, REG_CTRL, {29'h0, CMD_READ});
    wait_idle(1'b1);
    apb(1'b0, REG_RDATA, 32'h0);
    cmp("read_back", d, rd);
    $display("t_prog done");
  endtask : t_prog
  task automatic t_abort;
    apb(1'b1, REG_CTRL, {29'h0, CMD_WRITE});
    wait_idle(1'b0);
    cmp("abort_busy", 32'h0, rd & 32'h2);
    apb(1'b1, REG_CTRL, {29'h0, CMD_RESET});
    wait_idle(1'b1);
    cmp("abort_ready", 32'h2, rd & 32'h3);
    $display("t_abort done");
  endtask : t_abort
  task automatic t_midrst;
    apb(1'b1, REG_CTRL, {29'h0, CMD_WRITE});
    repeat (2) @(posedge core_clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    cmp("rst_pins", 32'hf, {28'h0, flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_reset_n_o});
    resetn_i <= 1'b1;
    apb(1'b0, REG_STATUS, 32'h0);
    cmp("rst_status", 32'h2, rd);
    $display("t_midrst done");
  endtask : t_midrst
  task automatic t_prot;
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, REG_ADDR, i ? 32'h0 : 32'h1fffff);
      apb(1'b1, REG_CTRL, {29'h0, i ? CMD_UNPROTECT : CMD_PROTECT});
      wait_idle(1'b1);
      cmp("prot_addr", i ? 32'h6 : 32'h2, {29'h0, we_addr[6], we_addr[1], we_addr[0]});
    end
    $display("t_prot done");
  endtask : t_prot
  task automatic t_temp;
    int n = 0;
    apb(1'b1, REG_CTRL, 32'h10 | {29'h0, CMD_WRITE});
    while (flash_we_n_o !== 1'b0 && n < 50) begin
      @(posedge core_clk_i);
      n++;
    end
    cmp("tu_setup", 32'h1, {31'h0, n > 4 && n < 50});
    wait_idle(1'b1);
    cmp("tu_on", 32'h10, rd & 32'h10);
    apb(1'b1, REG_CTRL, 32'h0);
    wait_idle(1'b1);
    cmp("tu_off", 32'h0, rd & 32'h10);
    $display("t_temp done");
  endtask : t_temp
  initial begin
    repeat (40000) @(posedge core_clk_i);
    errors++;
    $display("[ERR] watchdog expected finish seen hang");
    stop_test();
  end
  initial begin
    resetn_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h0;
    pwdata_i = 32'h0;
    repeat (10) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    t_regs();
    t_prog(32'h5, 32'ha5c3, 32'h0);
    t_prog(32'ha, 32'h3c5a, 32'h20);
    t_abort();
    t_midrst();
    t_prot();
    t_temp();
    stop_test();
  end
endmodule : flash_reset_program_erase_timing_bench
`default_nettype wire
